// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import tmoc_pkg::*;
;
    logic        aclk = 1'h0;
    logic        aresetn;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, port_value, pin_out, pin_oe_n, compare_output;
    logic        capture_event, irq_ack_a, irq_ack_b, irq;
    int          err_total = 0;
    int          num_checks = 0;
    tmoc_if      bus_if ();
    tmoc_host tmoc_host_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus(bus_if.cpu));
    tmoc_dev tmoc_dev_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if.dev), .capture_event(capture_event),
        .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b), .irq(irq), .port_value(port_value),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .compare_output(compare_output));
    tmoc_checker tmoc_checker_inst (.aclk(aclk), .aresetn(aresetn), .reg_addr(bus_if.reg_addr),
        .reg_wdata(bus_if.reg_wdata), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
        .reg_rdata(bus_if.reg_rdata), .port_value(port_value), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .compare_output(compare_output), .irq(irq));
    always #12.5 aclk = ~aclk;
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic a;
        logic w;
        a = 1'h1;
        w = 1'h1;
        awaddr <= {26'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (a || w) begin
            @(posedge aclk);
            if (a && awready) awvalid <= 1'h0;
            if (a && awready) a = 1'h0;
            if (w && wready) wvalid <= 1'h0;
            if (w && wready) w = 1'h0;
        end
        do begin
            @(posedge aclk);
        end while (!bvalid);
        check(16'(bresp), 16'(AXI_OKAY), "write response");
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp, input string what);
        araddr <= {26'h0, idx, 2'h0};
        arvalid <= 1'h1;
        do begin
            @(posedge aclk);
        end while (!arready);
        arvalid <= 1'h0;
        do begin
            @(posedge aclk);
        end while (!rvalid);
        check(16'(rresp), 16'(AXI_OKAY), "read response");
        check(rdata[15:0], {8'h00, exp}, what);
    endtask
    task automatic run_until_irq();
        int n;
        n = 0;
        wr(REG_CNT_H, 8'h00);
        wr(REG_CNT_L, 8'h00);
        wr(REG_CTRL_B, 8'h01);
        while (irq !== 1'h1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        wr(REG_CTRL_B, 8'h00);
        check(16'(irq), 16'h0001, "match irq");
    endtask
    task automatic t_regs();
        check(16'(compare_output), 16'h0000, "output after reset");
        rdchk(4'hE, 8'h00, "unmapped index");
        wr(REG_CMPA_H, 8'h12);
        wr(REG_CMPA_L, 8'h34);
        wr(REG_CMPB_H, 8'hAB);
        wr(REG_CMPB_L, 8'hCD);
        rdchk(REG_CMPA_L, 8'h34, "cmp a low");
        rdchk(REG_CMPA_H, 8'h12, "cmp a high");
        rdchk(REG_CNT_L, 8'h00, "count low");
        rdchk(REG_CMPB_H, 8'hAB, "cmp b high direct");
        rdchk(REG_CMPB_L, 8'hCD, "cmp b low");
    endtask
    task automatic t_force();
        logic [1:0] act [7] = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_CLEAR, ACT_NONE, ACT_SET, ACT_NONE};
        logic [6:0] exp = 7'h65;
        for (int i = 0; i < 7; i++) begin
            wr(REG_CTRL_A, {act[i], act[i], 4'h0});
            wr(REG_CTRL_C, 8'hC0);
            tick(2);
            check(16'(compare_output), {14'h0, exp[i], exp[i]}, "forced output");
        end
        rdchk(REG_IRQ_FLG, 8'h00, "force sets no flag");
    endtask
    task automatic t_pin();
        port_value <= 2'h0;
        wr(REG_CTRL_A, {ACT_TOGGLE, ACT_NONE, 4'h0});
        wr(REG_PIN_DIR, 8'h03);
        tick(2);
        check(16'(pin_oe_n), 16'h0000, "pins driven");
        check(16'(pin_out), 16'h0001, "pin a overridden");
        port_value <= 2'h2;
        tick(2);
        check(16'(pin_out), 16'h0003, "pin b follows port");
    endtask
    task automatic t_mode();
        wr(REG_CTRL_B, 8'h04);
        wr(REG_CTRL_A, {ACT_CLEAR, ACT_NONE, 4'h1});
        wr(REG_CTRL_C, 8'h80);
        tick(2);
        check(16'(compare_output), 16'h0003, "kept in pwm, force ignored");
        wr(REG_CTRL_B, 8'h00);
        wr(REG_CTRL_A, 8'h00);
        check(16'(compare_output), 16'h0003, "kept back in normal");
    endtask
    task automatic t_match();
        wr(REG_IRQ_MSK, 8'h02);
        wr(REG_CMPA_H, 8'h00);
        wr(REG_CMPA_L, 8'h10);
        run_until_irq();
        rdchk(REG_IRQ_FLG, 8'h02, "flag a set");
        wr(REG_IRQ_FLG, 8'h02);
        rdchk(REG_IRQ_FLG, 8'h00, "flag cleared by one");
        check(16'(irq), 16'h0000, "irq dropped");
        run_until_irq();
        irq_ack_a <= 1'h1;
        @(posedge aclk);
        irq_ack_a <= 1'h0;
        tick(2);
        check(16'(irq), 16'h0000, "irq dropped by service");
        rdchk(REG_IRQ_FLG, 8'h00, "flag cleared by service");
        wr(REG_CMPA_L, 8'h20);
        wr(REG_CNT_H, 8'h00);
        wr(REG_CNT_L, 8'h20);
        wr(REG_CTRL_B, 8'h01);
        tick(6);
        wr(REG_CTRL_B, 8'h00);
        rdchk(REG_IRQ_FLG, 8'h00, "match after count write blocked");
    endtask
    task automatic t_buffer();
        wr(REG_CTRL_A, 8'h01);
        wr(REG_CMPB_H, 8'h00);
        wr(REG_CMPB_L, 8'h80);
        wr(REG_CNT_L, 8'hFE);
        rdchk(REG_CMPB_L, 8'h80, "buffer read in pwm");
        wr(REG_CTRL_B, 8'h05);
        wr(REG_CTRL_B, 8'h00);
        wr(REG_CTRL_A, 8'h00);
        rdchk(REG_CMPB_L, 8'h80, "buffer loaded at wrap");
    endtask
    task automatic t_capture();
        wr(REG_CTRL_A, {ACT_SET, ACT_SET, 4'h0});
        for (int i = 1; i < 3; i++) begin
            wr(REG_CNT_H, 8'(i));
            wr(REG_CNT_L, 8'h34);
            capture_event <= 1'h1;
            @(posedge aclk);
            capture_event <= 1'h0;
        end
        rdchk(REG_CAP_L, 8'h34, "capture low");
        rdchk(REG_CAP_H, 8'h02, "newer capture kept");
        rdchk(REG_IRQ_FLG, 8'h20, "capture flag set");
        wr(REG_IRQ_FLG, 8'h20);
        rdchk(REG_IRQ_FLG, 8'h00, "capture flag cleared by one");
    endtask
    initial begin
        #500000;
        err_total++;
        stop_test();
    end
    initial begin
        aresetn = 1'h0;
        {awaddr, wdata, araddr} = 96'h0;
        {awvalid, wvalid, arvalid, capture_event, irq_ack_a, irq_ack_b} = 6'h00;
        {bready, rready} = 2'h3;
        wstrb = 4'hF;
        port_value = 2'h0;
        tick(4);
        aresetn <= 1'h1;
        tick(1);
        t_regs();
        t_force();
        t_pin();
        t_mode();
        t_match();
        t_buffer();
        t_capture();
        stop_test();
    end
endmodule

// ==== tmoc_checker.sv ====
`timescale 1ns/1ps
module tmoc_checker
    import tmoc_pkg::*;
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Register bus
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Device pins
    input wire logic [1:0] port_value,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] compare_output,
    input wire logic       irq
);
    logic [7:0]  ctl;
    logic [7:0]  msk;
    logic [1:0]  dir;
    logic [7:0]  tmp;
    logic [15:0] cmp;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Shadow of control writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= 8'h00;
            msk <= 8'h00;
            dir <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL_A) ctl <= reg_wdata;
            if (reg_addr == REG_IRQ_MSK) msk <= reg_wdata;
            if (reg_addr == REG_PIN_DIR) dir <= reg_wdata[1:0];
        end
    end
    // Shadow of compare A
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmp <= 8'h00;
            cmp <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == REG_CMPA_H) tmp <= reg_wdata;
            if (reg_addr == REG_CMPA_L) cmp <= {tmp, reg_wdata};
        end
    end
    property p_cmp_rst;
        disable iff (1'h0) !aresetn |=> compare_output == 2'h0 && pin_oe_n == 2'h3;
    endproperty
    a_cmp_rst: assert property (p_cmp_rst) else $error("reset state wrong");
    property p_oe;
        $past(dir) == dir && $past(dir, 2) == dir |-> pin_oe_n == ~dir;
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_pin_a;
        $past(ctl[7:6]) != 2'h0 |-> pin_out[0] == $past(compare_output[0]);
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a not overridden");
    property p_pin_b;
        $past(ctl[5:4]) == 2'h0 |-> pin_out[1] == $past(port_value[1]);
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b not port value");
    property p_hold_a;
        ctl[7:6] == 2'h0 |=> $stable(compare_output[0]);
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("output a moved with no action");
    property p_irq_off;
        !msk[FLAG_A_BIT] && !msk[FLAG_B_BIT] && !msk[FLAG_CAP_BIT] |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
    property p_cmp_lo;
        reg_rd && reg_addr == REG_CMPA_L |=> reg_rdata == cmp[7:0];
    endproperty
    a_cmp_lo: assert property (p_cmp_lo) else $error("compare low read wrong");
    property p_cmp_hi;
        reg_rd && reg_addr == REG_CMPA_H |=> reg_rdata == cmp[15:8];
    endproperty
    a_cmp_hi: assert property (p_cmp_hi) else $error("compare high read wrong");
    property p_wr_once;
        reg_wr |=> !reg_wr;
    endproperty
    a_wr_once: assert property (p_wr_once) else $error("write not a pulse");
    c_irq: cover property (irq);
    c_hi_rd: cover property (reg_rd && reg_addr == REG_CMPA_H);
    c_out: cover property ($rose(compare_output[0]));
endmodule

// ==== tmoc_dev.sv ====
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - New capture overwrites unread captured count
// - Equal count and compare sets flag two cycles later
// - Flag with enable interrupts; ack (A, B only) or one clears
// - Output from match, mode, action, TOP, BOTTOM
// - Channel A compare can define counter TOP
// - PWM modes buffer compare, load at BOTTOM
// - CPU writes buffer in PWM, active otherwise
// - Compare only CPU-written; high read is direct
// - High byte latched; low write loads both
// - Force strobe acts like match in non-PWM modes, no flag
// - Count write blocks next timer cycle's matches
// - Count written at variable TOP runs to max
// - Output bit survives waveform mode changes
// - Output action unbuffered, takes effect next match
// - Reset clears compare output bits
// - Nonzero action overrides pin value; direction separate
// - Output action never affects capture
// - Action zero leaves output unchanged on match
// - Software swaps capture edge then clears flag
// - Software sets output bit before pin direction
// - Modes 4 and 12 clear on match; 0 normal
// - Modes 5,6,7,14,15 are fast PWM
module tmoc_dev
    import tmoc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Register bus
    tmoc_if.dev             bus,
    // Capture and interrupt service
    input  wire logic       capture_event,
    input  wire logic       irq_ack_a,
    input  wire logic       irq_ack_b,
    output logic            irq,
    // Port pins for channels A and B
    input  wire logic [1:0] port_value,
    output logic [1:0]      pin_out,
    output logic [1:0]      pin_oe_n,
    output logic [1:0]      compare_output
);
    logic [1:0]  act_a, act_b;
    logic [3:0]  waveform_mode_sel;
    logic        run;
    logic [15:0] timer_count, capture_value;
    logic [15:0] cmp_a, cmp_b, buf_a, buf_b;
    logic [7:0]  temp;
    logic [7:0]  timer_irq_mask_reg;
    logic        flag_a, flag_b, capture_flag;
    logic        block;
    logic        match_a_q, match_b_q;
    logic [1:0]  pin_direction_bit;
    logic [15:0] top;
    logic        pwm, wrap, match_a, match_b, wr_cnt;

    function automatic logic is_pwm(input logic [3:0] m);
        return !(m == WGM_NORMAL || m == WGM_CTC_A || m == WGM_CTC_CAP || m == WGM_RESERVED);
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a, input logic [15:0] c);
        unique case (m)
            4'h1, 4'h5:               return TOP_8BIT;
            4'h2, 4'h6:               return TOP_9BIT;
            4'h3, 4'h7:               return TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF:   return a;
            4'h8, 4'hA, 4'hC, 4'hE:   return c;
            default:                  return CNT_MAX;
        endcase
    endfunction

    // Output bit on a match or force
    function automatic logic on_match(input logic [1:0] act, input logic oc, input logic p);
        if (p) begin
            return (act == ACT_CLEAR) ? 1'b0 : (act == ACT_SET) ? 1'b1 : oc;
        end
        unique case (act)
            ACT_TOGGLE: return ~oc;
            ACT_CLEAR:  return 1'b0;
            ACT_SET:    return 1'b1;
            default:    return oc;
        endcase
    endfunction

    // Output bit at BOTTOM in PWM
    function automatic logic at_bottom(input logic [1:0] act, input logic oc);
        return (act == ACT_CLEAR) ? 1'b1 : (act == ACT_SET) ? 1'b0 : oc;
    endfunction

    function automatic logic wr_at(input logic [3:0] a);
        return bus.reg_wr && bus.reg_addr == a;
    endfunction

    assign pwm     = is_pwm(waveform_mode_sel);
    assign top     = top_of(waveform_mode_sel, cmp_a, capture_value);
    assign wr_cnt  = wr_at(REG_CNT_L);
    assign match_a = run && !block && timer_count == cmp_a;
    assign match_b = run && !block && timer_count == cmp_b;
    assign wrap    = run && (timer_count == CNT_MAX || (!block && timer_count == top));

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_a <= ACT_NONE;
            act_b <= ACT_NONE;
            waveform_mode_sel <= WGM_NORMAL;
            run <= 1'b0;
            timer_irq_mask_reg <= BYTE_ZERO;
            pin_direction_bit <= 2'h0;
        end else begin
            if (wr_at(REG_CTRL_A)) begin
                act_a <= bus.reg_wdata[ACT_A_LSB +: 2];
                act_b <= bus.reg_wdata[ACT_B_LSB +: 2];
                waveform_mode_sel[1:0] <= bus.reg_wdata[WGM_LO_LSB +: 2];
            end
            if (wr_at(REG_CTRL_B)) begin
                waveform_mode_sel[3:2] <= bus.reg_wdata[WGM_HI_LSB +: 2];
                run <= bus.reg_wdata[RUN_BIT];
            end
            if (wr_at(REG_IRQ_MSK)) begin
                timer_irq_mask_reg <= bus.reg_wdata;
            end
            if (wr_at(REG_PIN_DIR)) begin
                pin_direction_bit <= bus.reg_wdata[1:0];
            end
        end
    end

    // Shared high-byte latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp <= BYTE_ZERO;
        end else if (bus.reg_wr && (bus.reg_addr == REG_CNT_H || bus.reg_addr == REG_CMPA_H ||
                     bus.reg_addr == REG_CMPB_H || bus.reg_addr == REG_CAP_H)) begin
            temp <= bus.reg_wdata;
        end else if (bus.reg_rd && bus.reg_addr == REG_CNT_L) begin
            temp <= timer_count[15:8];
        end else if (bus.reg_rd && bus.reg_addr == REG_CAP_L) begin
            temp <= capture_value[15:8];
        end
    end

    // Counter and match blocking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count <= CNT_ZERO;
            block <= 1'b0;
        end else begin
            if (wr_cnt) begin
                timer_count <= {temp, bus.reg_wdata};
                block <= 1'b1;
            end else if (run) begin
                timer_count <= wrap ? CNT_ZERO : timer_count + CNT_STEP;
                block <= 1'b0;
            end
        end
    end

    // Compare values, buffers and capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_a <= CNT_ZERO;
            cmp_b <= CNT_ZERO;
            buf_a <= CNT_ZERO;
            buf_b <= CNT_ZERO;
            capture_value <= CNT_ZERO;
        end else begin
            if (wr_at(REG_CMPA_L)) begin
                buf_a <= {temp, bus.reg_wdata};
            end
            if (wr_at(REG_CMPB_L)) begin
                buf_b <= {temp, bus.reg_wdata};
            end
            if (!pwm) begin
                if (wr_at(REG_CMPA_L)) begin
                    cmp_a <= {temp, bus.reg_wdata};
                end
                if (wr_at(REG_CMPB_L)) begin
                    cmp_b <= {temp, bus.reg_wdata};
                end
            end else if (wrap && !wr_cnt) begin
                cmp_a <= buf_a;
                cmp_b <= buf_b;
            end
            if (capture_event && waveform_mode_sel != WGM_CTC_CAP) begin
                capture_value <= timer_count;
            end else if (wr_at(REG_CAP_L) && top == capture_value) begin
                capture_value <= {temp, bus.reg_wdata};
            end
        end
    end

    // Flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
            flag_a <= 1'b0;
            flag_b <= 1'b0;
            capture_flag <= 1'b0;
        end else begin
            match_a_q <= match_a;
            match_b_q <= match_b;
            flag_a <= match_a_q || (flag_a && !irq_ack_a &&
                      !(wr_at(REG_IRQ_FLG) && bus.reg_wdata[FLAG_A_BIT]));
            flag_b <= match_b_q || (flag_b && !irq_ack_b &&
                      !(wr_at(REG_IRQ_FLG) && bus.reg_wdata[FLAG_B_BIT]));
            capture_flag <= (capture_event && waveform_mode_sel != WGM_CTC_CAP) || (capture_flag &&
                            !(wr_at(REG_IRQ_FLG) && bus.reg_wdata[FLAG_CAP_BIT]));
        end
    end

    // Waveform generator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_output <= 2'h0;
        end else begin
            if (!pwm && wr_at(REG_CTRL_C) && bus.reg_wdata[FORCE_A_BIT]) begin
                compare_output[0] <= on_match(act_a, compare_output[0], 1'b0);
            end else if (match_a) begin
                compare_output[0] <= on_match(act_a, compare_output[0], pwm);
            end else if (pwm && wrap) begin
                compare_output[0] <= at_bottom(act_a, compare_output[0]);
            end
            if (!pwm && wr_at(REG_CTRL_C) && bus.reg_wdata[FORCE_B_BIT]) begin
                compare_output[1] <= on_match(act_b, compare_output[1], 1'b0);
            end else if (match_b) begin
                compare_output[1] <= on_match(act_b, compare_output[1], pwm);
            end else if (pwm && wrap) begin
                compare_output[1] <= at_bottom(act_b, compare_output[1]);
            end
        end
    end

    // Pins, interrupt and read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 2'h0;
            pin_oe_n <= 2'h3;
            irq <= 1'b0;
            bus.reg_rdata <= BYTE_ZERO;
        end else begin
            pin_out[0] <= (act_a != ACT_NONE) ? compare_output[0] : port_value[0];
            pin_out[1] <= (act_b != ACT_NONE) ? compare_output[1] : port_value[1];
            pin_oe_n <= ~pin_direction_bit;
            irq <= (flag_a && timer_irq_mask_reg[FLAG_A_BIT]) ||
                   (flag_b && timer_irq_mask_reg[FLAG_B_BIT]) ||
                   (capture_flag && timer_irq_mask_reg[FLAG_CAP_BIT]);
            if (bus.reg_rd) begin
                unique case (bus.reg_addr)
                    REG_CTRL_A:  bus.reg_rdata <= {act_a, act_b, 2'h0, waveform_mode_sel[1:0]};
                    REG_CTRL_B:  bus.reg_rdata <= {4'h0, waveform_mode_sel[3:2], 1'b0, run};
                    REG_CNT_L:   bus.reg_rdata <= timer_count[7:0];
                    REG_CNT_H:   bus.reg_rdata <= temp;
                    REG_CMPA_L:  bus.reg_rdata <= pwm ? buf_a[7:0] : cmp_a[7:0];
                    REG_CMPA_H:  bus.reg_rdata <= pwm ? buf_a[15:8] : cmp_a[15:8];
                    REG_CMPB_L:  bus.reg_rdata <= pwm ? buf_b[7:0] : cmp_b[7:0];
                    REG_CMPB_H:  bus.reg_rdata <= pwm ? buf_b[15:8] : cmp_b[15:8];
                    REG_CAP_L:   bus.reg_rdata <= capture_value[7:0];
                    REG_CAP_H:   bus.reg_rdata <= temp;
                    REG_IRQ_MSK: bus.reg_rdata <= timer_irq_mask_reg;
                    REG_IRQ_FLG: bus.reg_rdata <= {2'h0, capture_flag, 2'h0, flag_b, flag_a, 1'b0};
                    REG_PIN_DIR: bus.reg_rdata <= {6'h0, pin_direction_bit};
                    default:     bus.reg_rdata <= BYTE_ZERO;
                endcase
            end
        end
    end
endmodule

// ==== tmoc_host.sv ====
`timescale 1ns/1ps
module tmoc_host
    import tmoc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Register bus to the timer
    tmoc_if.cpu              bus
);
    typedef enum logic [2:0] {S_IDLE, S_BRESP, S_RD1, S_RD2, S_RRESP} tmoc_state_t;
    tmoc_state_t st;
    logic       aw_got, w_got, wr_go;
    logic [3:0] aw_idx;
    logic [7:0] w_byte;
    logic       w_lane;

    // Write launches when both halves held and no read is taken now
    assign wr_go = aw_got && w_got && !(arvalid && arready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= S_IDLE;
            awready <= 1'b1;
            wready <= 1'b1;
            arready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_idx <= 4'h0;
            w_byte <= BYTE_ZERO;
            w_lane <= 1'b0;
            bvalid <= 1'b0;
            bresp <= AXI_OKAY;
            rvalid <= 1'b0;
            rresp <= AXI_OKAY;
            rdata <= 32'h0000_0000;
            bus.reg_addr <= 4'h0;
            bus.reg_wdata <= BYTE_ZERO;
            bus.reg_wr <= 1'b0;
            bus.reg_rd <= 1'b0;
        end else begin
            bus.reg_wr <= 1'b0;
            bus.reg_rd <= 1'b0;
            if (awvalid && awready) begin
                aw_got <= 1'b1;
                awready <= 1'b0;
                aw_idx <= awaddr[AXI_IDX_LSB +: 4];
            end
            if (wvalid && wready) begin
                w_got <= 1'b1;
                wready <= 1'b0;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
            end
            unique case (st)
                S_IDLE: begin
                    if (arvalid && arready) begin
                        arready <= 1'b0;
                        bus.reg_addr <= araddr[AXI_IDX_LSB +: 4];
                        bus.reg_rd <= 1'b1;
                        st <= S_RD1;
                    end else if (wr_go) begin
                        arready <= 1'b0;
                        bus.reg_addr <= aw_idx;
                        bus.reg_wdata <= w_byte;
                        bus.reg_wr <= w_lane;
                        aw_got <= 1'b0;
                        w_got <= 1'b0;
                        bvalid <= 1'b1;
                        st <= S_BRESP;
                    end
                end
                S_BRESP: begin
                    if (bready) begin
                        bvalid <= 1'b0;
                        awready <= 1'b1;
                        wready <= 1'b1;
                        arready <= 1'b1;
                        st <= S_IDLE;
                    end
                end
                S_RD1: st <= S_RD2;
                S_RD2: begin
                    rdata <= {24'h00_0000, bus.reg_rdata};
                    rvalid <= 1'b1;
                    st <= S_RRESP;
                end
                S_RRESP: begin
                    if (rready) begin
                        rvalid <= 1'b0;
                        arready <= 1'b1;
                        st <= S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ==== tmoc_if.sv ====
`timescale 1ns/1ps
interface tmoc_if;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    modport dev (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, output reg_rdata);
    modport cpu (output reg_addr, output reg_wdata, output reg_wr, output reg_rd, input reg_rdata);
endinterface

// ==== tmoc_pkg.sv ====
package tmoc_pkg;
    // Register indexes on the 8-bit register bus
    localparam logic [3:0] REG_CTRL_A  = 4'h0;
    localparam logic [3:0] REG_CTRL_B  = 4'h1;
    localparam logic [3:0] REG_CTRL_C  = 4'h2;
    localparam logic [3:0] REG_CNT_L   = 4'h3;
    localparam logic [3:0] REG_CNT_H   = 4'h4;
    localparam logic [3:0] REG_CMPA_L  = 4'h5;
    localparam logic [3:0] REG_CMPA_H  = 4'h6;
    localparam logic [3:0] REG_CMPB_L  = 4'h7;
    localparam logic [3:0] REG_CMPB_H  = 4'h8;
    localparam logic [3:0] REG_CAP_L   = 4'h9;
    localparam logic [3:0] REG_CAP_H   = 4'hA;
    localparam logic [3:0] REG_IRQ_MSK = 4'hB;
    localparam logic [3:0] REG_IRQ_FLG = 4'hC;
    localparam logic [3:0] REG_PIN_DIR = 4'hD;
    // Field positions
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int WGM_LO_LSB = 0;
    localparam int WGM_HI_LSB = 2;
    localparam int RUN_BIT = 0;
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam int FLAG_A_BIT = 1;
    localparam int FLAG_B_BIT = 2;
    localparam int FLAG_CAP_BIT = 5;
    // Waveform modes
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    localparam logic [3:0] WGM_CTC_A    = 4'h4;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WGM_RESERVED = 4'hD;
    // Output actions
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;
    // Counter constants
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CNT_STEP  = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    // Host-side AXI
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam int AXI_IDX_LSB = 2;
endpackage
